/* sim/uer_host_model.sv */
`timescale 1ns/100ps
// ****
// Low-speed host stand-in
// ****
module uer_host_model (
	input  wire logic         clk,
	input  wire logic         rx_ready,
	output logic              tok_stb,
	output uer_pkg::uer_tok_t tok_pid,
	output logic [1:0]        tok_ep,
	output logic              tok_ok,
	output logic              data_start,
	output logic              data_end,
	output logic [4:0]        data_cnt,
	output logic              data_ok,
	output logic              data_tog,
	output logic              rx_valid,
	output logic [7:0]        rx_data,
	output logic              in_end,
	output logic              in_acked
);
	// Quiet bus at start
	initial begin
		{tok_stb, tok_ep, tok_ok, data_start, data_end, data_cnt} = '0;
		{data_ok, data_tog, rx_valid, rx_data, in_end, in_acked} = '0;
		tok_pid = uer_pkg::UER_TOK_SETUP;
	end
	// One token, then its data packet or the host handshake
	task automatic xact(input logic [1:0] ep, input logic [1:0] pid, input logic [4:0] cnt,
		input logic tog, input logic [1:0] ok);
		int k;
		@(negedge clk);
		{tok_stb, tok_ok, tok_ep, tok_pid} = {1'h1, ok[1], ep, uer_pkg::uer_tok_t'(pid)};
		@(negedge clk);
		tok_stb = 1'h0;
		if (pid == 2'h1) begin
			@(negedge clk);
			{in_end, in_acked} = 2'h3; // Host always acknowledges
			@(negedge clk);
			{in_end, in_acked} = 2'h0;
		end else begin
			data_start = 1'h1;
			@(negedge clk);
			data_start = 1'h0;
			// Each byte held until the responder can take it
			for (int i = 0; i < cnt && i < 12; i++) begin
				{rx_valid, rx_data} = {1'h1, 8'($urandom)};
				k = 0;
				while (!rx_ready && k < 50) begin
					@(negedge clk);
					k++;
				end
				if (k == 50)
					uer_mode_responder_tb.hang();
				@(negedge clk);
			end
			{rx_valid, rx_data} = {1'h0, ~rx_data}; // Released line does not keep its value
			{data_end, data_cnt, data_ok, data_tog} = {1'h1, cnt, ok[0], tog};
			@(negedge clk);
			data_end = 1'h0;
		end
	endtask
endmodule

/* sim/uer_mode_responder_tb.sv */
`timescale 1ns/100ps
// ****
// Mode responder bench
// ****
module uer_mode_responder_tb;
	logic clk, rstn, tok_stb, tok_ok, data_start, data_end, data_ok, data_tog, rx_valid, rx_ready;
	logic in_end, in_acked, wr_valid, wr_ready, rsp_stb, lock, cpu_mode_wr, cpu_cnt_wr, cpu_rd;
	logic [1:0] tok_ep, cpu_ep;
	logic [3:0] cpu_wdata;
	logic [4:0] data_cnt, c;
	logic [7:0] rx_data;
	logic [2:0] irq, seen_irq;
	uer_pkg::uer_tok_t tok_pid;
	uer_pkg::uer_rsp_t rsp_kind, seen_rsp;
	uer_pkg::uer_byte_t wr_byte;
	uer_pkg::uer_ep_t [2:0] ep_st;
	int n_mismatch, n_tests, n_kept;
	uer_mode_responder #(.N_EP(3)) u_uer_mode_responder (.*);
	uer_host_model u_uer_host_model (.*);
	// Clock
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// Capture of answers and interrupts; slow drain stalls the byte path
	always @(posedge clk) begin
		if (rsp_stb === 1'h1)
			seen_rsp <= rsp_kind;
		seen_irq <= seen_irq | irq;
		if (wr_valid === 1'h1 && wr_ready && wr_byte.keep === 1'h1)
			n_kept <= n_kept + 1;
	end
	always @(negedge clk)
		wr_ready <= ($urandom % 4) == 0;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang;
		n_mismatch++;
		test_done();
	endtask
	// Mode the engine falls back to after an ACK
	function automatic logic [3:0] f_drop(input logic [3:0] m);
		return m & 4'hE;
	endfunction
	// Processor access: sel 0 mode write, 1 count write, 2 read
	task automatic cpu(input logic [1:0] ep, input logic [1:0] sel, input logic [3:0] v);
		@(negedge clk);
		{cpu_ep, cpu_wdata} = {ep, v};
		{cpu_mode_wr, cpu_cnt_wr, cpu_rd} = 3'h4 >> sel;
		@(negedge clk);
		{cpu_mode_wr, cpu_cnt_wr, cpu_rd} = 3'h0;
		@(negedge clk);
	endtask
	// One transaction and the answer, mode and interrupt it leaves behind
	task automatic step(input logic [1:0] ep, input logic [1:0] pid, input logic [4:0] cnt, input logic tog,
		input logic [1:0] ok, input logic [2:0] rsp, input logic [3:0] m, input logic iq);
		{seen_rsp, seen_irq} = '0;
		u_uer_host_model.xact(ep, pid, cnt, tog, ok);
		repeat (3) @(negedge clk);
		check(16'(seen_rsp), 16'(rsp));
		check(16'(ep_st[ep].mode), 16'(m));
		check(16'(seen_irq), 16'({2'h0, iq}) << ep);
		$display("step ep %0d token %0d done", ep, pid);
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'h07E6B687));
		{rstn, wr_ready, cpu_ep, cpu_mode_wr, cpu_cnt_wr, cpu_rd, cpu_wdata} = '0;
		{seen_rsp, seen_irq} = '0;
		repeat (16) @(negedge clk);
		rstn = 1'h1;
		for (int e = 0; e < 3; e++)
			check(16'(ep_st[e].mode), 16'h0);
		step(2'h0, 2'h0, 5'h0A, 1'h0, 2'h3, 3'h0, 4'h0, 1'h0);
		cpu(2'h0, 2'h0, 4'h1);
		c = 5'(3 + $urandom % 8);
		step(2'h0, 2'h0, c, 1'h0, 2'h3, 3'h1, 4'h1, 1'h1);
		check(16'({ep_st[0].dval, ep_st[0].setup_f, ep_st[0].ack_f, lock}), 16'hF);
		cpu(2'h0, 2'h0, 4'h3);
		cpu(2'h0, 2'h1, 4'h5);
		check(16'({ep_st[0].mode, ep_st[0].count}), 16'({4'h1, c[3:0]}));
		cpu(2'h0, 2'h2, 4'h0);
		check(16'(lock), 16'h0);
		cpu(2'h0, 2'h0, 4'h3);
		step(2'h0, 2'h1, 5'h00, 1'h0, 2'h3, 3'h3, 4'h3, 1'h1);
		check(16'(ep_st[0].in_f), 16'h1);
		step(2'h0, 2'h0, 5'h0B, 1'h0, 2'h3, 3'h0, 4'h3, 1'h1);
		check(16'({ep_st[0].dval, ep_st[0].setup_f}), 16'h1);
		step(2'h0, 2'h1, 5'h00, 1'h0, 2'h1, 3'h0, 4'h3, 1'h0);
		cpu(2'h1, 2'h0, 4'h8);
		step(2'h1, 2'h0, 5'h05, 1'h0, 2'h3, 3'h0, 4'h8, 1'h0);
		step(2'h1, 2'h1, 5'h00, 1'h0, 2'h3, 3'h0, 4'h8, 1'h0);
		step(2'h1, 2'h2, 5'h05, 1'h0, 2'h3, 3'h2, 4'h8, 1'h1);
		cpu(2'h1, 2'h0, 4'hB);
		step(2'h1, 2'h2, 5'h05, 1'h1, 2'h2, 3'h0, 4'hB, 1'h1);
		step(2'h1, 2'h2, c, 1'h1, 2'h3, 3'h1, f_drop(4'hB), 1'h1);
		step(2'h1, 2'h1, 5'h00, 1'h0, 2'h3, 3'h4, 4'hA, 1'h1);
		cpu(2'h1, 2'h0, 4'hD);
		step(2'h1, 2'h1, 5'h00, 1'h0, 2'h3, 3'h5, f_drop(4'hD), 1'h1);
		cpu(2'h2, 2'h0, 4'h6);
		step(2'h2, 2'h2, c, 1'h0, 2'h3, 3'h3, 4'h3, 1'h1);
		cpu(2'h2, 2'h0, 4'h2);
		step(2'h2, 2'h2, 5'h02, 1'h1, 2'h3, 3'h1, 4'h2, 1'h1);
		step(2'h2, 2'h2, 5'h02, 1'h0, 2'h3, 3'h3, 4'h3, 1'h1);
		cpu(2'h2, 2'h0, 4'h2);
		step(2'h2, 2'h2, 5'h04, 1'h1, 2'h3, 3'h3, 4'h3, 1'h1);
		check(16'(n_kept), 16'(2 * c + 16));
		test_done();
	end
endmodule

/* verilog/uer_buf2.sv */
`timescale 1ns/100ps
module uer_buf2 #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic             main_v_ff;
	logic             skid_v_ff;
	logic [WIDTH-1:0] main_ff;
	logic [WIDTH-1:0] skid_ff;
	logic             push;
	logic             refill;

	if (DEPTH != 2 || WIDTH < 1) begin : g_chk
		$error("uer_buf2 serves two entries of at least one bit");
	end

	// Main entry faces the drain, skid entry catches a stalled word
	assign push      = in_valid && !skid_v_ff;
	assign refill    = out_ready || !main_v_ff;
	assign in_ready  = !skid_v_ff;
	assign out_valid = main_v_ff;
	assign out_data  = main_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			main_v_ff <= 1'b0;
			skid_v_ff <= 1'b0;
			main_ff   <= '0;
			skid_ff   <= '0;
		end else begin
			main_v_ff <= refill ? (skid_v_ff || push) : 1'b1;
			main_ff   <= refill ? (skid_v_ff ? skid_ff : (push ? in_data : main_ff)) : main_ff;
			skid_v_ff <= refill ? 1'b0 : (skid_v_ff || push);
			skid_ff   <= (push && !refill) ? in_data : skid_ff;
		end
	end
endmodule

/* verilog/uer_defs.svh */
`ifndef UER_DEFS_SVH
`define UER_DEFS_SVH

// ****************************************************************
// Endpoint mode encodings
// ****************************************************************
`define UER_M_DISABLE     4'h0
`define UER_M_NAKIO       4'h1
`define UER_M_STOUT       4'h2
`define UER_M_STALLIO     4'h3
`define UER_M_IGNIO       4'h4
`define UER_M_ISOOUT      4'h5
`define UER_M_STIN        4'h6
`define UER_M_ISOIN       4'h7
`define UER_M_NAKOUT      4'h8
`define UER_M_ACKOUT      4'h9
`define UER_M_NAKOUT_STIN 4'hA
`define UER_M_ACKOUT_STIN 4'hB
`define UER_M_NAKIN       4'hC
`define UER_M_ACKIN       4'hD
`define UER_M_NAKIN_STOUT 4'hE
`define UER_M_ACKIN_STOUT 4'hF

// ****************************************************************
// Counts and timing
// ****************************************************************
`define UER_MAX_CNT  5'h0A
`define UER_STAT_CNT 5'h02
`define UER_CNT_SAT  4'hF
`define UER_LOCK_NS  1000
`define UER_CLK_NS   100
`define UER_LOCK_CYC ((`UER_LOCK_NS + `UER_CLK_NS - 1) / `UER_CLK_NS)
`endif

/* verilog/uer_ep_reg.sv */
`timescale 1ns/100ps
`include "uer_defs.svh"
module uer_ep_reg (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              upd_v,
	input  wire uer_pkg::uer_upd_t upd,
	input  wire logic              mode_wr,
	input  wire logic              cnt_wr,
	input  wire logic [3:0]        wdata,
	output uer_pkg::uer_ep_t       st
);
	uer_pkg::uer_ep_t st_ff;
	uer_pkg::uer_ep_t nxt_st;

	// Processor writes first, engine updates override them
	always_comb begin
		nxt_st = st_ff;
		if (mode_wr) begin
			nxt_st.mode    = wdata;
			nxt_st.setup_f = 1'b0;
			nxt_st.in_f    = 1'b0;
			nxt_st.out_f   = 1'b0;
			nxt_st.ack_f   = 1'b0;
		end
		if (cnt_wr) begin
			nxt_st.count = wdata;
		end
		if (upd_v && upd.set_mode) begin
			nxt_st.mode = upd.mode;
		end
		if (upd_v && upd.set_data) begin
			nxt_st.data_toggle_bit = upd.data_toggle_bit;
			nxt_st.dval            = upd.dval;
			nxt_st.count           = upd.count;
		end
		if (upd_v) begin
			nxt_st.setup_f = nxt_st.setup_f | upd.setup_f;
			nxt_st.in_f    = nxt_st.in_f | upd.in_f;
			nxt_st.out_f   = nxt_st.out_f | upd.out_f;
			nxt_st.ack_f   = nxt_st.ack_f | upd.ack_f;
		end
	end

	assign st = st_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_ff      <= '0;
			st_ff.mode <= `UER_M_DISABLE;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule

/* verilog/uer_mode_responder.sv */
`timescale 1ns/100ps
`include "uer_defs.svh"
module uer_mode_responder #(
	parameter int N_EP = 3
) (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   tok_stb,
	input  wire uer_pkg::uer_tok_t      tok_pid,
	input  wire logic [1:0]             tok_ep,
	input  wire logic                   tok_ok,
	input  wire logic                   data_start,
	input  wire logic                   data_end,
	input  wire logic [4:0]             data_cnt,
	input  wire logic                   data_ok,
	input  wire logic                   data_tog,
	input  wire logic                   rx_valid,
	output logic                        rx_ready,
	input  wire logic [7:0]             rx_data,
	input  wire logic                   in_end,
	input  wire logic                   in_acked,
	output logic                        wr_valid,
	input  wire logic                   wr_ready,
	output uer_pkg::uer_byte_t          wr_byte,
	output logic                        rsp_stb,
	output uer_pkg::uer_rsp_t           rsp_kind,
	output logic [N_EP-1:0]             irq,
	output logic                        lock,
	input  wire logic [1:0]             cpu_ep,
	input  wire logic                   cpu_mode_wr,
	input  wire logic                   cpu_cnt_wr,
	input  wire logic [3:0]             cpu_wdata,
	input  wire logic                   cpu_rd,
	output uer_pkg::uer_ep_t [N_EP-1:0] ep_st
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	uer_pkg::uer_state_t state_ff;
	uer_pkg::uer_state_t nxt_state;
	uer_pkg::uer_tok_t   pid_ff;
	uer_pkg::uer_tok_t   nxt_pid;
	logic [1:0]          ep_ff;
	logic [1:0]          nxt_ep;
	logic                keep_ff;
	logic                nxt_keep;
	logic                rsp_stb_ff;
	logic                nxt_rsp_stb;
	uer_pkg::uer_rsp_t   rsp_kind_ff;
	uer_pkg::uer_rsp_t   nxt_rsp_kind;
	logic [N_EP-1:0]     irq_ff;
	logic [N_EP-1:0]     nxt_irq;
	logic                lock_ff;
	logic                nxt_lock;
	logic                upd_v;
	logic                irq_req;
	logic                ack_xfer;
	uer_pkg::uer_upd_t   upd;
	logic [3:0]          tok_mode;
	logic [3:0]          cur_mode;
	logic                tok_hit;
	logic                data_good;
	logic                data_big;
	logic [3:0]          cnt_sat;
	logic                lock_set;
	logic                lock_clr;
	uer_pkg::uer_rsp_t   tok_in_rsp;
	uer_pkg::uer_byte_t  buf_in;

	if (N_EP < 1 || N_EP > 4) begin : g_chk
		$error("uer_mode_responder serves one to four endpoints");
	end

	// ****************************************************************
	// Mode decoding
	// ****************************************************************
	// Modes that take a Setup
	function automatic logic takes_setup(input logic [3:0] m);
		case (m)
			`UER_M_NAKIO, `UER_M_STOUT, `UER_M_STALLIO, `UER_M_IGNIO, `UER_M_STIN,
			`UER_M_NAKOUT_STIN, `UER_M_ACKOUT_STIN, `UER_M_NAKIN_STOUT, `UER_M_ACKIN_STOUT: takes_setup = 1'b1;
			default: takes_setup = 1'b0;
		endcase
	endfunction

	// Modes that do not drop an Out token
	function automatic logic takes_out(input logic [3:0] m);
		case (m)
			`UER_M_DISABLE, `UER_M_IGNIO, `UER_M_ISOIN, `UER_M_NAKIN, `UER_M_ACKIN: takes_out = 1'b0;
			default: takes_out = 1'b1;
		endcase
	endfunction

	// Modes whose Out data lands in the buffer
	function automatic logic stores_out(input logic [3:0] m);
		stores_out = (m == `UER_M_ISOOUT) || (m == `UER_M_ACKOUT) || (m == `UER_M_ACKOUT_STIN);
	endfunction

	// Answer to an In token per mode
	function automatic uer_pkg::uer_rsp_t in_answer(input logic [3:0] m);
		case (m)
			`UER_M_NAKIO, `UER_M_NAKIN, `UER_M_NAKIN_STOUT:        in_answer = uer_pkg::UER_RSP_NAK;
			`UER_M_STOUT, `UER_M_STALLIO:                         in_answer = uer_pkg::UER_RSP_STALL;
			`UER_M_STIN, `UER_M_NAKOUT_STIN, `UER_M_ACKOUT_STIN:  in_answer = uer_pkg::UER_RSP_TX0;
			`UER_M_ISOIN, `UER_M_ACKIN, `UER_M_ACKIN_STOUT:       in_answer = uer_pkg::UER_RSP_TXCNT;
			default:                                              in_answer = uer_pkg::UER_RSP_NONE;
		endcase
	endfunction

	// Token qualification and current endpoint mode
	assign tok_hit    = tok_stb && tok_ok && ({1'b0, tok_ep} < 3'(N_EP));
	assign tok_mode   = tok_hit ? ep_st[tok_ep].mode : `UER_M_DISABLE;
	assign cur_mode   = ep_st[ep_ff].mode;
	assign tok_in_rsp = in_answer(tok_mode);
	assign data_big   = data_cnt > `UER_MAX_CNT;
	assign data_good  = data_ok && !data_big;
	assign cnt_sat    = data_big ? `UER_CNT_SAT : data_cnt[3:0];

	// ****************************************************************
	// Transaction decisions
	// ****************************************************************
	always_comb begin
		nxt_state    = state_ff;
		nxt_pid      = pid_ff;
		nxt_ep       = ep_ff;
		nxt_keep     = keep_ff;
		nxt_rsp_stb  = 1'b0;
		nxt_rsp_kind = rsp_kind_ff;
		upd_v        = 1'b0;
		irq_req      = 1'b0;
		ack_xfer     = 1'b0;
		upd          = '0;
		if (tok_stb) begin
			// A new token always starts over, a stuck phase is abandoned
			nxt_state = uer_pkg::UER_ST_IDLE;
			nxt_ep    = tok_ep;
			nxt_pid   = tok_pid;
			nxt_keep  = 1'b0;
			if (tok_hit && tok_pid == uer_pkg::UER_TOK_SETUP && takes_setup(tok_mode)) begin
				nxt_state = uer_pkg::UER_ST_RXDATA;
				nxt_keep  = 1'b1;
			end else if (tok_hit && tok_pid == uer_pkg::UER_TOK_OUT && takes_out(tok_mode)) begin
				nxt_state = uer_pkg::UER_ST_RXDATA;
				nxt_keep  = stores_out(tok_mode);
			end else if (tok_hit && tok_pid == uer_pkg::UER_TOK_IN && tok_in_rsp != uer_pkg::UER_RSP_NONE) begin
				nxt_rsp_stb  = 1'b1;
				nxt_rsp_kind = tok_in_rsp;
				if (tok_in_rsp == uer_pkg::UER_RSP_NAK || tok_in_rsp == uer_pkg::UER_RSP_STALL) begin
					upd_v     = 1'b1;
					upd.in_f  = 1'b1;
					irq_req   = 1'b1;
				end else begin
					nxt_state = uer_pkg::UER_ST_TXWAIT;
				end
			end
		end else if (state_ff == uer_pkg::UER_ST_RXDATA && data_start && pid_ff == uer_pkg::UER_TOK_SETUP) begin
			upd_v       = 1'b1;
			upd.setup_f = 1'b1;
		end else if (state_ff == uer_pkg::UER_ST_RXDATA && data_end) begin
			nxt_state = uer_pkg::UER_ST_IDLE;
			nxt_keep  = 1'b0;
			upd.data_toggle_bit = data_tog;
			upd.dval            = data_good;
			upd.count           = cnt_sat;
			if (pid_ff == uer_pkg::UER_TOK_SETUP) begin
				// Setup always overwrites the buffer and interrupts
				upd_v        = 1'b1;
				irq_req      = 1'b1;
				upd.set_data = 1'b1;
				if (data_good) begin
					upd.ack_f    = 1'b1;
					upd.set_mode = 1'b1;
					upd.mode     = `UER_M_NAKIO;
					ack_xfer     = 1'b1;
					nxt_rsp_stb  = 1'b1;
					nxt_rsp_kind = uer_pkg::UER_RSP_ACK;
				end
			end else begin
				case (cur_mode)
					`UER_M_NAKIO, `UER_M_STALLIO: begin
						upd_v        = data_good;
						upd.out_f    = 1'b1;
						irq_req      = data_good;
						nxt_rsp_stb  = data_good;
						nxt_rsp_kind = (cur_mode == `UER_M_NAKIO) ? uer_pkg::UER_RSP_NAK : uer_pkg::UER_RSP_STALL;
					end
					`UER_M_ISOOUT: begin
						upd_v        = 1'b1;
						upd.set_data = 1'b1;
						upd.out_f    = 1'b1;
						upd.ack_f    = 1'b1;
						irq_req      = 1'b1;
					end
					`UER_M_STIN: begin
						upd_v        = data_good;
						upd.out_f    = 1'b1;
						upd.set_mode = 1'b1;
						upd.mode     = `UER_M_STALLIO;
						irq_req      = data_good;
						nxt_rsp_stb  = data_good;
						nxt_rsp_kind = uer_pkg::UER_RSP_STALL;
					end
					`UER_M_NAKOUT, `UER_M_NAKOUT_STIN: begin
						upd_v        = data_good;
						upd.out_f    = 1'b1;
						irq_req      = data_good;
						nxt_rsp_stb  = data_good;
						nxt_rsp_kind = uer_pkg::UER_RSP_NAK;
					end
					`UER_M_ACKOUT, `UER_M_ACKOUT_STIN: begin
						// Bad data still lands in the buffer as junk
						upd_v        = 1'b1;
						upd.set_data = 1'b1;
						upd.out_f    = 1'b1;
						irq_req      = 1'b1;
						upd.ack_f    = data_good;
						upd.set_mode = data_good;
						upd.mode     = (cur_mode == `UER_M_ACKOUT) ? `UER_M_NAKOUT : `UER_M_NAKOUT_STIN;
						ack_xfer     = data_good;
						nxt_rsp_stb  = data_good;
						nxt_rsp_kind = uer_pkg::UER_RSP_ACK;
					end
					`UER_M_STOUT, `UER_M_NAKIN_STOUT, `UER_M_ACKIN_STOUT: begin
						upd_v        = data_good;
						upd.set_data = 1'b1;
						upd.out_f    = 1'b1;
						irq_req      = data_good;
						nxt_rsp_stb  = data_good;
						if (data_cnt == `UER_STAT_CNT && data_tog) begin
							upd.ack_f    = 1'b1;
							ack_xfer     = data_good;
							nxt_rsp_kind = uer_pkg::UER_RSP_ACK;
						end else begin
							upd.set_mode = 1'b1;
							upd.mode     = `UER_M_STALLIO;
							nxt_rsp_kind = uer_pkg::UER_RSP_STALL;
						end
					end
					default: begin
						upd_v = 1'b0;
					end
				endcase
			end
		end else if (state_ff == uer_pkg::UER_ST_TXWAIT && in_end) begin
			// In flag only once the host handshake window has closed
			nxt_state    = uer_pkg::UER_ST_IDLE;
			upd_v        = in_acked || (cur_mode == `UER_M_ISOIN);
			upd.in_f     = 1'b1;
			upd.ack_f    = in_acked;
			ack_xfer     = in_acked;
			irq_req      = upd_v;
			upd.set_mode = in_acked && (cur_mode == `UER_M_ACKIN || cur_mode == `UER_M_ACKIN_STOUT);
			upd.mode     = (cur_mode == `UER_M_ACKIN) ? `UER_M_NAKIN : `UER_M_NAKIN_STOUT;
		end
	end

	// ****************************************************************
	// Interrupt, lock and endpoint status
	// ****************************************************************
	// Lock is set by an ACK on endpoint 0, cleared by a read while idle
	assign lock_set = ack_xfer && upd_v && (ep_ff == 2'h0) && !tok_stb;
	assign lock_clr = cpu_rd && (state_ff == uer_pkg::UER_ST_IDLE);
	assign nxt_lock = lock_set || (lock_ff && !lock_clr);

	for (genvar i = 0; i < N_EP; i++) begin : g_ep
		logic wr_ok;
		logic ep_upd;
		assign wr_ok  = (cpu_ep == 2'(i)) && !(i == 0 && lock_ff);
		assign ep_upd = upd_v && (nxt_ep == 2'(i));
		assign nxt_irq[i] = irq_req && (nxt_ep == 2'(i));
		uer_ep_reg u_ep (
			.clk     (clk),
			.rstn    (rstn),
			.upd_v   (ep_upd),
			.upd     (upd),
			.mode_wr (cpu_mode_wr && wr_ok),
			.cnt_wr  (cpu_cnt_wr && wr_ok),
			.wdata   (cpu_wdata),
			.st      (ep_st[i])
		);
	end

	// ****************************************************************
	// Receive byte path
	// ****************************************************************
	// Every byte passes the buffer, keep marks those the buffer memory takes
	assign buf_in.keep = keep_ff && (state_ff == uer_pkg::UER_ST_RXDATA);
	assign buf_in.data = rx_data;

	uer_buf2 #(
		.WIDTH ($bits(uer_pkg::uer_byte_t)),
		.DEPTH (2)
	) u_buf (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   (buf_in),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_byte)
	);

	assign rsp_stb  = rsp_stb_ff;
	assign rsp_kind = rsp_kind_ff;
	assign irq      = irq_ff;
	assign lock     = lock_ff;

	// State registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff    <= uer_pkg::UER_ST_IDLE;
			pid_ff      <= uer_pkg::UER_TOK_SETUP;
			ep_ff       <= 2'h0;
			keep_ff     <= 1'b0;
			rsp_stb_ff  <= 1'b0;
			rsp_kind_ff <= uer_pkg::UER_RSP_NONE;
			irq_ff      <= '0;
			lock_ff     <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			pid_ff      <= nxt_pid;
			ep_ff       <= nxt_ep;
			keep_ff     <= nxt_keep;
			rsp_stb_ff  <= nxt_rsp_stb;
			rsp_kind_ff <= nxt_rsp_kind;
			irq_ff      <= nxt_irq;
			lock_ff     <= nxt_lock;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic [7:0] lock_cnt;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_cnt <= 8'h00;
		end else begin
			lock_cnt <= lock_ff ? ((lock_cnt == 8'hFF) ? lock_cnt : lock_cnt + 8'h01) : 8'h00;
		end
	end

	bad_data_quiet_a: assert property (
		(state_ff == uer_pkg::UER_ST_RXDATA && data_end && !tok_stb && !data_good) |=> !rsp_stb)
		else $error("handshake sent for an invalid data packet");

	ack_irq_a: assert property (
		(rsp_stb && rsp_kind == uer_pkg::UER_RSP_ACK) |-> (irq != '0))
		else $error("ACK sent without an endpoint interrupt");

	setup_ignored_a: assert property (
		(tok_hit && tok_pid == uer_pkg::UER_TOK_SETUP && !takes_setup(tok_mode))
		|=> (state_ff == uer_pkg::UER_ST_IDLE && !rsp_stb))
		else $error("Setup taken by a non-control mode");

	in_ignored_a: assert property (
		(tok_hit && tok_pid == uer_pkg::UER_TOK_IN && (tok_mode == `UER_M_ACKOUT || tok_mode == `UER_M_NAKOUT))
		|=> (!rsp_stb && irq == '0))
		else $error("In token answered by an Out endpoint");

	setup_flag_a: assert property (
		(state_ff == uer_pkg::UER_ST_RXDATA && pid_ff == uer_pkg::UER_TOK_SETUP && data_start && !tok_stb)
		|=> ep_st[ep_ff].setup_f)
		else $error("Setup flag not set at data phase start");

	lock_set_a: assert property (
		(rsp_stb && rsp_kind == uer_pkg::UER_RSP_ACK && ep_ff == 2'h0) |-> lock)
		else $error("endpoint 0 not locked after ACK");

	lock_hold_a: assert property (
		(lock && !cpu_rd) |=> lock)
		else $error("lock released without a read");

	wr_block_a: assert property (
		(lock && cpu_ep == 2'h0 && (cpu_mode_wr || cpu_cnt_wr) && !(upd_v && nxt_ep == 2'h0))
		|=> ($stable(ep_st[0].mode) && $stable(ep_st[0].count)))
		else $error("endpoint 0 written while locked");

	setup_ack_a: assert property (
		(state_ff == uer_pkg::UER_ST_RXDATA && pid_ff == uer_pkg::UER_TOK_SETUP && data_end && data_good && !tok_stb)
		|=> (rsp_stb && rsp_kind == uer_pkg::UER_RSP_ACK && ep_st[ep_ff].mode == `UER_M_NAKIO))
		else $error("good Setup not ACKed into NAK-both");

	ack_out_drop_a: assert property (
		(state_ff == uer_pkg::UER_ST_RXDATA && cur_mode == `UER_M_ACKOUT_STIN && pid_ff == uer_pkg::UER_TOK_OUT
		&& data_end && data_good && !tok_stb)
		|=> (rsp_kind == uer_pkg::UER_RSP_ACK && ep_st[ep_ff].mode == `UER_M_NAKOUT_STIN))
		else $error("ACK-Out did not drop to NAK-Out");

	status_check_a: assert property (
		(state_ff == uer_pkg::UER_ST_RXDATA && cur_mode == `UER_M_STOUT && pid_ff == uer_pkg::UER_TOK_OUT
		&& data_end && data_good && data_cnt != `UER_STAT_CNT && !tok_stb)
		|=> (rsp_stb && rsp_kind == uer_pkg::UER_RSP_STALL && ep_st[ep_ff].mode == `UER_M_STALLIO))
		else $error("failed status check not stalled");

	setup_cov_c: cover property (rsp_stb && rsp_kind == uer_pkg::UER_RSP_ACK && ep_st[0].setup_f);
	tx_ack_c: cover property (state_ff == uer_pkg::UER_ST_TXWAIT && in_end && in_acked);
	stall_c: cover property (rsp_stb && rsp_kind == uer_pkg::UER_RSP_STALL);
	lock_long_c: cover property (lock_cnt == 8'(`UER_LOCK_CYC));
endmodule

/* verilog/uer_pkg.sv */
package uer_pkg;
	typedef enum logic [1:0] {UER_TOK_SETUP = 2'h0, UER_TOK_IN = 2'h1, UER_TOK_OUT = 2'h2} uer_tok_t;
	typedef enum logic [2:0] {
		UER_RSP_NONE = 3'h0, UER_RSP_ACK = 3'h1, UER_RSP_NAK = 3'h2,
		UER_RSP_STALL = 3'h3, UER_RSP_TX0 = 3'h4, UER_RSP_TXCNT = 3'h5
	} uer_rsp_t;
	typedef enum logic [1:0] {UER_ST_IDLE = 2'h0, UER_ST_RXDATA = 2'h1, UER_ST_TXWAIT = 2'h2} uer_state_t;
	typedef struct packed {logic keep; logic [7:0] data;} uer_byte_t;
	typedef struct packed {
		logic [3:0] mode;
		logic       data_toggle_bit;
		logic       dval;
		logic [3:0] count;
		logic       setup_f;
		logic       in_f;
		logic       out_f;
		logic       ack_f;
	} uer_ep_t;
	typedef struct packed {
		logic       set_mode;
		logic [3:0] mode;
		logic       set_data;
		logic       data_toggle_bit;
		logic       dval;
		logic [3:0] count;
		logic       setup_f;
		logic       in_f;
		logic       out_f;
		logic       ack_f;
	} uer_upd_t;
endpackage
